// [logic/emu_bank_arbiter.sv]
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Bus losing a same-bank collision gets emulation memory clocks added to its wait.
// - Bank with instruction priority grants the instruction bus first on collision.
// - Bank with data priority grants the data bus first on collision.
// - Data lock on: data bus ready waits for target ready.
// - Data lock off: data bus ready follows memory timing only.
// - Instruction lock on: instruction bus ready waits for target ready.
// - Real-time on with user code running: reject host register or target requests.
// - Host emulation memory requests are still served under real-time restriction.
// - Locked access finishes memory first, ignores earlier target ready, then waits.
// - Instruction lock off: instruction ready ignores target ready.
module emu_bank_arbiter #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire em_arb_pkg::bus_req_t ibus_req,
    output logic                      ibus_ready,
    input  wire em_arb_pkg::bus_req_t dbus_req,
    output logic                      dbus_ready,
    input  wire em_arb_pkg::bus_req_t host_req,
    input  wire logic                 host_needs_target,
    output logic                      host_done,
    output logic                      host_accept,
    output logic                      host_reject,
    input  wire logic                 user_running,
    input  wire logic                 target_ready
);

    em_arb_pkg::arb_state_t s_q;
    em_arb_pkg::arb_state_t s_d;

    logic [2:0]      req;
    logic [2:0]      req_bank;
    logic [2:0]      busy;
    logic [2:0]      done;
    logic [2:0]      elig;
    logic [2:0]      start;
    logic [2:0]      lose;
    logic [2:0]      lock;
    logic [1:0][2:0] gnt_bank;
    logic [1:0][2:0] lose_bank;
    logic [1:0]      bank_busy;
    logic [1:0]      prio;
    logic [3:0]      emu_clks;
    logic [3:0]      min_wait;
    logic            rt_on;

    // ----------------------------------------------------------------
    // Configuration fields
    // ----------------------------------------------------------------
    assign prio     = {s_q.ctrl[em_arb_pkg::CTRL_PRIO_B], s_q.ctrl[em_arb_pkg::CTRL_PRIO_A]};
    assign emu_clks = s_q.ctrl[em_arb_pkg::CTRL_CLKS_LSB +: em_arb_pkg::FIELD_W];
    assign min_wait = s_q.ctrl[em_arb_pkg::CTRL_WAIT_LSB +: em_arb_pkg::FIELD_W];
    assign rt_on    = s_q.ctrl[em_arb_pkg::CTRL_RT_ON];
    // Indexed by requester: bit0 instruction bus, bit1 data bus, host never locks
    assign lock     = {1'b0, s_q.ctrl[em_arb_pkg::CTRL_LOCK_D],
                       s_q.ctrl[em_arb_pkg::CTRL_LOCK_I]};

    // Host memory path arbitrates even under real-time restriction
    assign req      = {host_req.valid & ~host_needs_target, dbus_req.valid, ibus_req.valid};
    assign req_bank = {host_req.bank, dbus_req.bank, ibus_req.bank};
    // A done requester is still holding its request this cycle; skip it
    assign elig     = req & ~busy & ~done
                      & ~{bank_busy[req_bank[2]], bank_busy[req_bank[1]], bank_busy[req_bank[0]]};

    // ----------------------------------------------------------------
    // Per-bank arbitration
    // ----------------------------------------------------------------
    for (genvar b = 0; b < em_arb_pkg::NUM_BANK; b++)
    begin : g_bank
        logic hit_i;
        logic hit_d;
        logic hit_h;
        logic i_win;
        logic d_win;
        assign hit_i = elig[0] & (req_bank[0] == 1'(b));
        assign hit_d = elig[1] & (req_bank[1] == 1'(b));
        assign hit_h = elig[2] & (req_bank[2] == 1'(b));
        assign i_win = hit_i & (~hit_d | ~prio[b]);
        assign d_win = hit_d & (~hit_i | prio[b]);
        // Only one winner per bank; the other stays pending
        assign gnt_bank[b]  = {hit_h & ~hit_i & ~hit_d, d_win, i_win};
        assign lose_bank[b] = {1'b0, hit_d & ~d_win, hit_i & ~i_win};
        // Bank stays taken until its running access ends
        assign bank_busy[b] = |(busy & ~{s_q.act_bank[2] ^ 1'(b), s_q.act_bank[1] ^ 1'(b),
                                         s_q.act_bank[0] ^ 1'(b)});
    end

    assign start = gnt_bank[0] | gnt_bank[1];
    assign lose  = lose_bank[0] | lose_bank[1];

    // ----------------------------------------------------------------
    // Access timers, one per requester
    // ----------------------------------------------------------------
    for (genvar r = 0; r < em_arb_pkg::NUM_REQ; r++)
    begin : g_timer
        emu_access_timer u_timer (
            .core_clk     (core_clk),
            .rst          (rst),
            .start        (start[r]),
            .extra        (s_q.lost[r]),
            .lock         (lock[r]),
            .target_ready (target_ready),
            .emu_clks     (emu_clks),
            .min_wait     (min_wait),
            .busy         (busy[r]),
            .done         (done[r])
        );
    end

    // ----------------------------------------------------------------
    // Next state: bus slave, collision flags, host command filter
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d             = s_q;
        s_d.awready     = 1'b0;
        s_d.wready      = 1'b0;
        s_d.arready     = 1'b0;
        s_d.host_reject = 1'b0;
        s_d.host_accept = 1'b0;

        // Write: take address and data together, answer the cycle after
        if (s_axi_awvalid && s_axi_wvalid && !s_q.awready && !s_q.bvalid)
        begin
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end
        if (s_q.awready)
        begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = em_arb_pkg::RESP_OKAY;
            if (s_axi_awaddr == em_arb_pkg::ADDR_CTRL)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (s_axi_wstrb[i])
                    begin
                        s_d.ctrl[8*i +: 8] = s_axi_wdata[8*i +: 8];
                    end
                end
            end
            else if (s_axi_awaddr != em_arb_pkg::ADDR_STATUS)
            begin
                s_d.bresp = em_arb_pkg::RESP_SLVERR;
            end
        end
        else if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // Read: address taken, data the cycle after
        if (s_axi_arvalid && !s_q.arready && !s_q.rvalid)
        begin
            s_d.arready = 1'b1;
        end
        if (s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = em_arb_pkg::RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (s_axi_araddr == em_arb_pkg::ADDR_CTRL)
            begin
                s_d.rdata = s_q.ctrl;
            end
            else if (s_axi_araddr == em_arb_pkg::ADDR_STATUS)
            begin
                s_d.rdata[em_arb_pkg::STAT_BUSY_LSB +: 3] = busy;
                s_d.rdata[em_arb_pkg::STAT_LOST_LSB +: 3] = s_q.lost;
                s_d.rdata[em_arb_pkg::STAT_REJ_LSB +: 8]  = s_q.reject_cnt;
            end
            else
            begin
                s_d.rresp = em_arb_pkg::RESP_SLVERR;
            end
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // Collision penalty is remembered until the loser starts
        s_d.lost = (s_q.lost & ~start) | lose;
        for (int r = 0; r < 3; r++)
        begin
            if (start[r])
            begin
                s_d.act_bank[r] = req_bank[r];
            end
        end

        // Register and target commands; a request still held is answered again every second cycle
        if (host_req.valid && host_needs_target && !s_q.host_reject && !s_q.host_accept)
        begin
            if (rt_on && user_running)
            begin
                s_d.host_reject = 1'b1;
                if (s_q.reject_cnt != 8'hff)
                begin
                    s_d.reject_cnt = s_q.reject_cnt + 8'h01;
                end
            end
            else
            begin
                s_d.host_accept = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.ctrl <= em_arb_pkg::CTRL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = s_q.rdata;
    assign ibus_ready    = done[0];
    assign dbus_ready    = done[1];
    assign host_done     = done[2];
    assign host_reject   = s_q.host_reject;
    assign host_accept   = s_q.host_accept;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_instr_first: assert property (@(posedge core_clk) disable iff (rst)
        (elig[0] && elig[1] && req_bank[0] == req_bank[1] && !prio[req_bank[0]])
        |-> start[0] && !start[1] ##1 s_q.lost[1])
        else $error("instruction bus lost a bank it had priority on");
    chk_data_first: assert property (@(posedge core_clk) disable iff (rst)
        (elig[0] && elig[1] && req_bank[0] == req_bank[1] && prio[req_bank[0]])
        |-> start[1] && !start[0] ##1 s_q.lost[0])
        else $error("data bus lost a bank it had priority on");
    chk_one_grant: assert property (@(posedge core_clk) disable iff (rst)
        !(start[0] && start[1] && req_bank[0] == req_bank[1]))
        else $error("two grants to one bank");
    chk_host_last: assert property (@(posedge core_clk) disable iff (rst)
        start[2] |-> !(elig[0] && req_bank[0] == req_bank[2])
                     && !(elig[1] && req_bank[1] == req_bank[2]))
        else $error("host granted over a processor bus");
    chk_penalty_kept: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.lost[0] && !start[0]) |=> s_q.lost[0])
        else $error("collision penalty dropped before grant");
    chk_rt_reject: assert property (@(posedge core_clk) disable iff (rst)
        (host_req.valid && host_needs_target && rt_on && user_running
         && !s_q.host_reject && !s_q.host_accept) |=> host_reject && !host_accept)
        else $error("restricted host command not rejected");
    chk_rt_off_accept: assert property (@(posedge core_clk) disable iff (rst)
        (host_req.valid && host_needs_target && !rt_on
         && !s_q.host_reject && !s_q.host_accept) |=> host_accept && !host_reject)
        else $error("host command refused with restriction off");
    chk_mem_allowed: assert property (@(posedge core_clk) disable iff (rst)
        (host_req.valid && !host_needs_target && !busy[2] && !done[2]
         && !bank_busy[host_req.bank] && !elig[0] && !elig[1]) |-> start[2])
        else $error("host memory access blocked");

endmodule : emu_bank_arbiter

// [common/em_arb_pkg.sv]
package em_arb_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;

    // Control register fields
    localparam int CTRL_PRIO_A   = 0;  // 0: instruction bus wins bank A, 1: data bus
    localparam int CTRL_PRIO_B   = 1;  // Same for bank B
    localparam int CTRL_LOCK_D   = 2;  // Lock data bus ready to target ready
    localparam int CTRL_LOCK_I   = 3;  // Lock instruction bus ready to target ready
    localparam int CTRL_RT_ON    = 4;  // Real-time restriction
    localparam int CTRL_CLKS_LSB = 8;  // Clocks per emulation memory access
    localparam int CTRL_WAIT_LSB = 12; // Minimum access cycles
    localparam int FIELD_W       = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;

    // Status register fields
    localparam int STAT_BUSY_LSB = 0;
    localparam int STAT_LOST_LSB = 4;
    localparam int STAT_REJ_LSB  = 8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Requester indices
    localparam int REQ_I  = 0;
    localparam int REQ_D  = 1;
    localparam int REQ_H  = 2;
    localparam int NUM_REQ = 3;
    localparam int NUM_BANK = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        T_IDLE,
        T_ACCESS,
        T_LOCKWAIT
    } timer_state_t;

    typedef struct packed {
        timer_state_t st;
        logic [4:0]   cnt;
        logic         lock;
        logic         done;
    } timer_t;

    // Processor bus request: held until the matching ready pulse
    typedef struct packed {
        logic valid;
        logic bank;
    } bus_req_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [2:0]  lost;
        logic [2:0]  act_bank;
        logic        host_reject;
        logic        host_accept;
        logic [7:0]  reject_cnt;
    } arb_state_t;

endpackage : em_arb_pkg

// [logic/emu_access_timer.sv]
`timescale 1ns/100ps

module emu_access_timer (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       extra,
    input  wire logic       lock,
    input  wire logic       target_ready,
    input  wire logic [3:0] emu_clks,
    input  wire logic [3:0] min_wait,
    output logic            busy,
    output logic            done
);

    em_arb_pkg::timer_t s_q;
    em_arb_pkg::timer_t s_d;
    logic [4:0]         base;

    // ----------------------------------------------------------------
    // Access length and lock sequence
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // Never shorter than one cycle, even with both fields at zero
        base = (emu_clks > min_wait) ? {1'b0, emu_clks} : {1'b0, min_wait};
        if (base == 5'h0)
        begin
            base = 5'h1;
        end
        unique case (s_q.st)
            em_arb_pkg::T_IDLE:
            begin
                if (start)
                begin
                    s_d.st   = em_arb_pkg::T_ACCESS;
                    s_d.cnt  = base + (extra ? {1'b0, emu_clks} : 5'h0);
                    s_d.lock = lock;
                end
            end
            em_arb_pkg::T_ACCESS:
            begin
                if (s_q.cnt <= 5'h1)
                begin
                    // Memory side done; a locked access now waits for target
                    if (s_q.lock)
                    begin
                        s_d.st = em_arb_pkg::T_LOCKWAIT;
                    end
                    else
                    begin
                        s_d.st   = em_arb_pkg::T_IDLE;
                        s_d.done = 1'b1;
                    end
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 5'h1;
                end
            end
            em_arb_pkg::T_LOCKWAIT:
            begin
                // Only target ready seen after the memory access counts
                if (target_ready)
                begin
                    s_d.st   = em_arb_pkg::T_IDLE;
                    s_d.done = 1'b1;
                end
            end
            default:
            begin
                s_d.st = em_arb_pkg::T_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = (s_q.st != em_arb_pkg::T_IDLE);
    assign done = s_q.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_unlocked_end: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == em_arb_pkg::T_ACCESS && s_q.cnt <= 5'h1 && !s_q.lock) |=> done)
        else $error("unlocked access did not end on count");
    chk_locked_hold: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == em_arb_pkg::T_ACCESS && s_q.cnt <= 5'h1 && s_q.lock)
        |=> !done && s_q.st == em_arb_pkg::T_LOCKWAIT)
        else $error("locked access ended before target ready");
    chk_locked_release: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == em_arb_pkg::T_LOCKWAIT && target_ready) |=> done ##1 !done)
        else $error("locked access missed target ready");

endmodule : emu_access_timer

// [test/proc_bus_model.sv]
`timescale 1ns/100ps

// ------------------------------------------------
// Instruction and data bus requesters
// ------------------------------------------------
module proc_bus_model (
    input  wire logic            core_clk,
    input  wire logic            ibus_ready,
    input  wire logic            dbus_ready,
    output em_arb_pkg::bus_req_t ibus_req,
    output em_arb_pkg::bus_req_t dbus_req
);
    initial
    begin
        ibus_req = '0;
        dbus_req = '0;
    end

    // Holds the request until ready; bank flips on release so stale data never matches
    task automatic issue(input int w, input logic b, output int lat);
        int n;
        n = 0;
        @(posedge core_clk);
        if (w == 0) ibus_req <= '{1'b1, b};
        else dbus_req <= '{1'b1, b};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (((w == 0) ? ibus_ready : dbus_ready) !== 1'b1 && n < 200);
        if (w == 0) ibus_req <= '{1'b0, ~b};
        else dbus_req <= '{1'b0, ~b};
        lat = n;
    endtask : issue
endmodule : proc_bus_model

// [test/emulation_memory_bank_arbiter_tb_top.sv]
`timescale 1ns/100ps

module emulation_memory_bank_arbiter_tb_top;
    logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ibus_ready, dbus_ready;
    logic host_done, host_accept, host_reject, needs_tgt, user_running, target_ready;
    logic [1:0]  bresp, rresp, wr_resp;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    em_arb_pkg::bus_req_t ibus_req, dbus_req, host_req;
    int fail_count = 0;
    int compares = 0;
    int solo;

    emu_bank_arbiter emu_bank_arbiter_inst (.core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ibus_req(ibus_req),
        .ibus_ready(ibus_ready), .dbus_req(dbus_req), .dbus_ready(dbus_ready),
        .host_req(host_req), .host_needs_target(needs_tgt), .host_done(host_done),
        .host_accept(host_accept), .host_reject(host_reject),
        .user_running(user_running), .target_ready(target_ready));

    proc_bus_model proc_bus_model_inst (.core_clk(core_clk), .ibus_ready(ibus_ready),
        .dbus_ready(dbus_ready), .ibus_req(ibus_req), .dbus_req(dbus_req));

    always #2 core_clk = ~core_clk;

    // ------------------------------------------------
    // Bus tasks and compares
    // ------------------------------------------------
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %h", $time, m, g);
        end
    endtask : cmp_word

    task automatic cmp_true(input bit ok, input string m);
        compares++;
        if (!ok)
        begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : cmp_true

    // Address and data offered together, each released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) fail_count++;
        wr_resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) fail_count++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Host request held until any answer pulse
    task automatic host_op(input logic tgt, output logic [2:0] res, output int lat);
        lat = 0;
        @(posedge core_clk);
        host_req <= '{1'b1, 1'b0};
        needs_tgt <= tgt;
        do
        begin
            @(posedge core_clk);
            lat++;
        end
        while ({host_done, host_accept, host_reject} === 3'b000 && lat < 200);
        res = {host_done, host_accept, host_reject};
        host_req <= '{1'b0, 1'b1};
    endtask : host_op

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(em_arb_pkg::ADDR_CTRL, d, r);
        cmp_word(d, em_arb_pkg::CTRL_RST, "ctrl reset");
        axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_531f);
        cmp_word({30'h0, wr_resp}, {30'h0, em_arb_pkg::RESP_OKAY}, "write resp");
        axi_wr(12'h010, 32'h0000_0000);
        cmp_word({30'h0, wr_resp}, {30'h0, em_arb_pkg::RESP_SLVERR}, "unmapped write");
        axi_rd(em_arb_pkg::ADDR_CTRL, d, r);
        cmp_word(d, 32'h0000_531f, "ctrl readback");
        cmp_word({30'h0, r}, {30'h0, em_arb_pkg::RESP_OKAY}, "read resp");
        axi_rd(12'h010, d, r);
        cmp_word({30'h0, r}, {30'h0, em_arb_pkg::RESP_SLVERR}, "unmapped");
        $display("test regs done");
    endtask : t_regs

    // Three clocks per access so the loser's extra is plainly visible
    task automatic t_prio;
        int li, ld, w, l;
        logic b;
        axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_0300);
        proc_bus_model_inst.issue(0, 1'b0, solo);
        cmp_true(solo == 5, "solo latency");
        fork
            proc_bus_model_inst.issue(0, 1'b0, li);
            proc_bus_model_inst.issue(1, 1'b1, ld);
        join
        cmp_true(li == solo && ld == solo, "split banks");
        for (int c = 0; c < 4; c++)
        begin
            b = c[1];
            axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_0300 | (32'(c[0]) << b));
            fork
                proc_bus_model_inst.issue(0, b, li);
                proc_bus_model_inst.issue(1, b, ld);
            join
            w = c[0] ? ld : li;
            l = c[0] ? li : ld;
            cmp_true(w == solo, "winner latency");
            cmp_true(l >= w + solo + 1 && l <= w + solo + 5, "loser latency");
        end
        $display("test prio done");
    endtask : t_prio

    task automatic t_host;
        int li, ld, hl;
        logic [2:0] res;
        fork
            proc_bus_model_inst.issue(0, 1'b0, li);
            proc_bus_model_inst.issue(1, 1'b0, ld);
            host_op(1'b0, res, hl);
        join
        cmp_word({29'h0, res}, 32'h0000_0004, "host memory done");
        cmp_true(hl > li && hl > ld, "host ranks last");
        $display("test host done");
    endtask : t_host

    // Early target ready during the access must not end a locked cycle
    task automatic t_lock;
        int l;
        for (int w = 0; w < 2; w++)
        begin
            axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_0300 | (w ? 32'h4 : 32'h8));
            fork
                proc_bus_model_inst.issue(w, 1'b0, l);
                begin
                    @(posedge core_clk);
                    target_ready <= 1'b1;
                    repeat (2) @(posedge core_clk);
                    target_ready <= 1'b0;
                    repeat (solo + 6) @(posedge core_clk);
                    target_ready <= 1'b1;
                end
            join
            target_ready <= 1'b0;
            cmp_true(l >= solo + 8 && l <= solo + 11, "locked ready");
            axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_0300);
            proc_bus_model_inst.issue(w, 1'b0, l);
            cmp_true(l == solo, "unlocked ready");
        end
        $display("test lock done");
    endtask : t_lock

    task automatic t_rt;
        logic [2:0] res;
        int hl;
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 4; k++)
        begin
            axi_wr(em_arb_pkg::ADDR_CTRL, 32'h0000_0300 | (32'(k[0]) << 4));
            user_running <= k[1];
            host_op(1'b1, res, hl);
            cmp_word({29'h0, res}, (k == 3) ? 32'h1 : 32'h2, "target command");
        end
        host_op(1'b0, res, hl);
        cmp_word({29'h0, res}, 32'h0000_0004, "memory under restriction");
        // One refusal so far, all requesters idle, no collision pending
        axi_rd(em_arb_pkg::ADDR_STATUS, d, r);
        cmp_word(d, 32'h0000_0100, "status word");
        user_running <= 1'b0;
        $display("test realtime done");
    endtask : t_rt

    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    initial
    begin
        {core_clk, awvalid, wvalid, bready, arvalid, rready} = '0;
        {needs_tgt, user_running, target_ready, awaddr, araddr, wdata} = '0;
        host_req = '0;
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_prio();
        t_host();
        t_lock();
        t_rt();
        conclude();
    end
endmodule : emulation_memory_bank_arbiter_tb_top
